// ===== bench/aad_host_model.sv
// Host side model: APB master with register read and write tasks
module aad_host_model
  import aad_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // One transfer; request held until pready is seen at an edge, only the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    // Read data and error taken at the edge that sees pready
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~{24'h00_0000, d};
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, idx, d, q, e);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] q, output logic e);
    xfer(1'b0, idx, 8'h00, q, e);
  endtask
endmodule

// ===== bench/tb.sv
// Self-checking testbench for the aux channel activity detector
module tb;
  import aad_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic CLK_SYS, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, AUX_VALID, AXIS_VALID;
  logic AUX_ACT_EVENT, AUX_INACT_EVENT, X_CHECK_EN, Y_CHECK_EN, Z_CHECK_EN, IRQ;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic [SAMPLE_W-1:0] AUX_SAMPLE, ACCEL_X, ACCEL_Y, ACCEL_Z, TAP_SAMPLE;
  logic e;
  int fails, checked, na, ni, ea, ei;

  aad_top dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .AUX_VALID(AUX_VALID), .AUX_SAMPLE(AUX_SAMPLE), .AXIS_VALID(AXIS_VALID), .ACCEL_X(ACCEL_X),
    .ACCEL_Y(ACCEL_Y), .ACCEL_Z(ACCEL_Z), .AUX_ACT_EVENT(AUX_ACT_EVENT), .AUX_INACT_EVENT(AUX_INACT_EVENT),
    .TAP_SAMPLE(TAP_SAMPLE), .X_CHECK_EN(X_CHECK_EN), .Y_CHECK_EN(Y_CHECK_EN), .Z_CHECK_EN(Z_CHECK_EN),
    .IRQ(IRQ));

  aad_host_model host (.clk(CLK_SYS), .pready(PREADY), .prdata(PRDATA), .pslverr(PSLVERR), .psel(PSEL),
    .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA));

  // Clock, 40 ns period
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  // Event pulses counted at the edge; totals compared after each burst
  always @(posedge CLK_SYS) begin
    if (AUX_ACT_EVENT === 1'b1) na++;
    if (AUX_INACT_EVENT === 1'b1) ni++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    host.rd(idx, q, e);
    chk({q[31:1], e}, {24'h00_0000, exp[7:1], 1'b0});
    chk({31'h0, q[0]}, {31'h0, exp[0]});
  endtask

  // Back-to-back aux samples; the data bus toggles once valid drops
  task automatic run(input logic [13:0] s, input int n, input int da, input int di);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK_SYS);
      AUX_VALID  <= 1'b1;
      AUX_SAMPLE <= s;
    end
    @(posedge CLK_SYS);
    AUX_VALID  <= 1'b0;
    AUX_SAMPLE <= ~s;
    repeat (5) @(posedge CLK_SYS);
    ea += da;
    ei += di;
    chk(32'(na), 32'(ea));
    chk(32'(ni), 32'(ei));
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog sized well above the expected run of under two thousand cycles
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end

  initial begin
    RESET_N = 1'b0; AUX_VALID = 1'b0; AXIS_VALID = 1'b0; AUX_SAMPLE = 14'h0000;
    ACCEL_X = 14'h0111; ACCEL_Y = 14'h0222; ACCEL_Z = 14'h0333;
    repeat (4) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    for (int i = 8'h3c; i <= 8'h43; i++) rdchk(8'(i), 8'h00);
    host.rd(8'h7f, q, e);
    chk(q, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    // Limits: activity 0x0a5, inactivity 0x040; reserved bits written as ones
    host.wr(IDX_ACT_HI, 8'h82); rdchk(IDX_ACT_HI, 8'h02);
    host.wr(IDX_ACT_LO, 8'h97); rdchk(IDX_ACT_LO, 8'h94);
    host.wr(IDX_INACT_HI, 8'h81); rdchk(IDX_INACT_HI, 8'h01);
    host.wr(IDX_INACT_LO, 8'h03); rdchk(IDX_INACT_LO, 8'h00);
    host.wr(IDX_COUNTS, 8'h23); rdchk(IDX_COUNTS, 8'h23);
    host.wr(IDX_THERM_CTL, 8'h0b);
    run(14'h00a6, 2, 0, 0);
    run(14'h0064, 1, 0, 0);
    run(14'h00a6, 3, 1, 0);
    run(14'h00a5, 3, 0, 0);
    run(14'h3f5a, 3, 1, 0);
    run(14'h000a, 2, 0, 1);
    run(14'h3fc1, 2, 0, 1);
    run(14'h0040, 2, 0, 0);
    // Sticky status, enable and clear
    rdchk(IDX_IRQ_STATUS, 8'h03); chk({31'h0, IRQ}, 32'h0);
    host.wr(IDX_IRQ_ENABLE, 8'h02); repeat (2) @(posedge CLK_SYS); chk({31'h0, IRQ}, 32'h1);
    host.wr(IDX_IRQ_CLEAR, 8'h02); repeat (2) @(posedge CLK_SYS); chk({31'h0, IRQ}, 32'h0);
    rdchk(IDX_IRQ_STATUS, 8'h01);
    host.wr(IDX_IRQ_ENABLE, 8'h03); repeat (2) @(posedge CLK_SYS); chk({31'h0, IRQ}, 32'h1);
    host.wr(IDX_IRQ_CLEAR, 8'h01); repeat (2) @(posedge CLK_SYS); chk({31'h0, IRQ}, 32'h0);
    rdchk(IDX_IRQ_STATUS, 8'h00);
    // Channel enables
    host.wr(IDX_THERM_CTL, 8'h09); run(14'h00a6, 3, 0, 0);
    host.wr(IDX_CONV_CTL, 8'h0b); run(14'h00a6, 3, 0, 0);
    host.wr(IDX_THERM_CTL, 8'h00); run(14'h00a6, 3, 1, 0);
    host.wr(IDX_CONV_CTL, 8'h09); run(14'h00a6, 3, 0, 0);
    run(14'h000a, 2, 0, 1);
    // Axis mask blocks
    host.wr(IDX_AXIS_MASK, 8'hc5); repeat (3) @(posedge CLK_SYS);
    chk({29'h0, X_CHECK_EN, Y_CHECK_EN, Z_CHECK_EN}, 32'h2);
    rdchk(IDX_AXIS_MASK, 8'h05);
    host.wr(IDX_AXIS_MASK, 8'h02); repeat (3) @(posedge CLK_SYS);
    chk({29'h0, X_CHECK_EN, Y_CHECK_EN, Z_CHECK_EN}, 32'h5);
    // Mid-run reset puts every axis check back on and clears the mask
    @(posedge CLK_SYS);
    RESET_N <= 1'b0;
    @(posedge CLK_SYS);
    chk({29'h0, X_CHECK_EN, Y_CHECK_EN, Z_CHECK_EN}, 32'h7);
    RESET_N <= 1'b1;
    rdchk(IDX_AXIS_MASK, 8'h00);
    // Tap axis codes, code 11 gives zero
    for (int c = 0; c < 4; c++) begin
      host.wr(IDX_AXIS_MASK, {2'b00, 2'(c), 4'h0});
      @(posedge CLK_SYS); AXIS_VALID <= 1'b1;
      @(posedge CLK_SYS); AXIS_VALID <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      chk({18'h0, TAP_SAMPLE}, (c == 3) ? 32'h0 : 32'h111 * (c + 1));
    end
    tally_and_finish();
  end
endmodule

// ===== logic/aad_pkg.sv
// Package: register map, field layout and reset values for the aux channel activity detector
package aad_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0]  IDX_ACT_HI      = 8'h3e;
  localparam logic [7:0]  IDX_ACT_LO      = 8'h3f;
  localparam logic [7:0]  IDX_INACT_HI    = 8'h40;
  localparam logic [7:0]  IDX_INACT_LO    = 8'h41;
  localparam logic [7:0]  IDX_COUNTS      = 8'h42;
  localparam logic [7:0]  IDX_AXIS_MASK   = 8'h43;
  localparam logic [7:0]  IDX_CONV_CTL    = 8'h3c;
  localparam logic [7:0]  IDX_THERM_CTL   = 8'h3d;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h50;
  localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'h51;
  localparam logic [7:0]  IDX_IRQ_CLEAR   = 8'h52;
  // Field positions
  localparam int          LIM_HI_MSB      = 6;
  localparam int          LIM_LO_LSB      = 2;
  localparam int          CNT_QUIET_LSB   = 4;
  localparam int          CNT_BUSY_LSB    = 0;
  localparam int          TAP_AXIS_LSB    = 4;
  localparam int          MASK_Z_BIT      = 2;
  localparam int          MASK_Y_BIT      = 1;
  localparam int          MASK_X_BIT      = 0;
  localparam int          CTL_INACT_BIT   = 3;
  localparam int          CTL_ACT_BIT     = 1;
  localparam int          CTL_EN_BIT      = 0;
  localparam int          IRQ_ACT_BIT     = 0;
  localparam int          IRQ_INACT_BIT   = 1;
  // Writable bit masks; reserved bits stay zero
  localparam logic [7:0]  MSK_LIM_HI      = 8'h7f;
  localparam logic [7:0]  MSK_LIM_LO      = 8'hfc;
  localparam logic [7:0]  MSK_COUNTS      = 8'hff;
  localparam logic [7:0]  MSK_AXIS        = 8'h37;
  localparam logic [7:0]  MSK_CTL         = 8'h0f;
  localparam logic [7:0]  MSK_IRQ         = 8'h03;
  // Reset values
  localparam logic [7:0]  RST_REG         = 8'h00;
  localparam logic [7:0]  RST_CONV_CTL    = 8'h00;
  // Widths
  localparam int          SAMPLE_W        = 14;
  localparam int          LIMIT_W         = 13;
  localparam int          COUNT_W         = 4;
  // Tap axis codes
  localparam logic [1:0]  TAP_X           = 2'h0;
  localparam logic [1:0]  TAP_Y           = 2'h1;
  localparam logic [1:0]  TAP_Z           = 2'h2;
endpackage

// ===== logic/aad_qualifier.sv
// Consecutive-sample qualifier: counts samples that meet a condition, fires when the count is reached
module aad_qualifier
  import aad_pkg::*;
#(
  parameter int CW = COUNT_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          enable,
  input  wire logic          sample_valid,
  input  wire logic          hit,
  input  wire logic [CW-1:0] need,
  output logic               event_pulse
);
  logic [CW-1:0] run_r;

  // Run length of consecutive hits; a miss or a disable restarts the run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r       <= '0;
      event_pulse <= 1'b0;
    end else begin
      event_pulse <= 1'b0;
      if (!enable) begin
        run_r <= '0;
      end else if (sample_valid) begin
        if (!hit) begin
          run_r <= '0;
        end else if ((run_r + 1'b1) >= need || need == '0) begin
          // Count of zero fires on the first qualifying sample
          event_pulse <= 1'b1;
          run_r       <= '0;
        end else begin
          run_r <= run_r + 1'b1;
        end
      end
    end
  end
endmodule

// ===== logic/aad_top.sv
// Aux channel activity and inactivity detector with axis mask, APB register slave
// Summary of operation
// - Activity compares the magnitude of each signed 14-bit aux sample with the 13-bit activity limit.
// - The activity limit low six bits sit in bits 7:2 at 0x3F, bits 1:0 reserved.
// - Inactivity compares sample magnitude with a 13-bit limit whose upper seven bits sit in bits 6:0 at 0x40.
// - The inactivity limit low six bits sit in bits 7:2 at 0x41, bits 1:0 reserved.
// - Limits are raw codes compared directly with the magnitude, no scaling.
// - Inactivity fires after the count in timer bits 7:4 of consecutive samples below the inactivity limit.
// - Activity fires after the count in timer bits 3:0 of consecutive samples above the activity limit.
// - Tap axis field 5:4 selects x for 00, y for 01 and z for 10.
// - Mask bit 2 set blocks the z-axis from activity and inactivity checking; clear by reset.
// - Mask bit 1 set blocks the y-axis from activity and inactivity checking.
// - Mask bit 0 set blocks the x-axis from activity and inactivity checking.
// - The activity limit upper seven bits sit in bits 6:0 at 0x3E, bit 7 reserved.
// - Thermal activity and inactivity detection each run only while their own enable bit is one.
// - Converter activity and inactivity detection each run only while their own enable bit is set.
// - With thermal conversion enabled the converter enable has no effect; the channel is thermal only.
//
// Design decision made here: the APB interface to the registers.
module aad_top
  import aad_pkg::*;
(
  input  wire logic                CLK_SYS,
  input  wire logic                RESET_N,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [11:0]         PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic                     PREADY,
  output logic [31:0]              PRDATA,
  output logic                     PSLVERR,
  input  wire logic                AUX_VALID,
  input  wire logic [SAMPLE_W-1:0] AUX_SAMPLE,
  input  wire logic                AXIS_VALID,
  input  wire logic [SAMPLE_W-1:0] ACCEL_X,
  input  wire logic [SAMPLE_W-1:0] ACCEL_Y,
  input  wire logic [SAMPLE_W-1:0] ACCEL_Z,
  output logic                     AUX_ACT_EVENT,
  output logic                     AUX_INACT_EVENT,
  output logic [SAMPLE_W-1:0]      TAP_SAMPLE,
  output logic                     X_CHECK_EN,
  output logic                     Y_CHECK_EN,
  output logic                     Z_CHECK_EN,
  output logic                     IRQ
);
  logic [7:0]          act_hi_r;
  logic [7:0]          act_lo_r;
  logic [7:0]          inact_hi_r;
  logic [7:0]          inact_lo_r;
  logic [7:0]          counts_r;
  logic [7:0]          axis_mask_r;
  logic [7:0]          conv_ctl_r;
  logic [7:0]          therm_ctl_r;
  logic [1:0]          irq_status_r;
  logic [1:0]          irq_enable_r;
  logic [LIMIT_W-1:0]  act_limit;
  logic [LIMIT_W-1:0]  inact_limit;
  logic [SAMPLE_W-1:0] magnitude;
  logic                therm_on;
  logic                conv_on;
  logic                act_en;
  logic                inact_en;
  logic                act_pulse;
  logic                inact_pulse;
  logic                wr_acc;
  logic                rd_acc;
  logic [9:0]          word_idx;
  logic                idx_ok;
  logic [7:0]          rd_nxt;
  logic [1:0]          clr_bits;

  // Byte address is four times the register index
  assign word_idx = PADDR[11:2];
  assign wr_acc   = PSEL && PENABLE && PWRITE && !PREADY;
  assign rd_acc   = PSEL && PENABLE && !PWRITE && !PREADY;

  // Limits assembled from their high and low parts
  assign act_limit   = {act_hi_r[LIM_HI_MSB:0], act_lo_r[7:LIM_LO_LSB]};
  assign inact_limit = {inact_hi_r[LIM_HI_MSB:0], inact_lo_r[7:LIM_LO_LSB]};

  // Absolute value of the signed sample; most negative code gives its exact magnitude 0x2000, read unsigned
  assign magnitude = AUX_SAMPLE[SAMPLE_W-1] ? SAMPLE_W'(-AUX_SAMPLE) : AUX_SAMPLE;

  // Thermal mode overrides the converter enable
  assign therm_on = therm_ctl_r[CTL_EN_BIT];
  assign conv_on  = conv_ctl_r[CTL_EN_BIT] && !therm_on;
  // Per-function enables for whichever source owns the channel
  assign act_en   = therm_on ? therm_ctl_r[CTL_ACT_BIT] : (conv_on && conv_ctl_r[CTL_ACT_BIT]);
  assign inact_en = therm_on ? therm_ctl_r[CTL_INACT_BIT] : (conv_on && conv_ctl_r[CTL_INACT_BIT]);

  // Activity: magnitude above the limit, raw codes, no scaling
  aad_qualifier #(.CW(COUNT_W)) u_act (
    .clk          (CLK_SYS),
    .rst_n        (RESET_N),
    .enable       (act_en),
    .sample_valid (AUX_VALID),
    .hit          (magnitude > {1'b0, act_limit}),
    .need         (counts_r[CNT_BUSY_LSB +: COUNT_W]),
    .event_pulse  (act_pulse)
  );

  // Inactivity: magnitude below the limit
  aad_qualifier #(.CW(COUNT_W)) u_inact (
    .clk          (CLK_SYS),
    .rst_n        (RESET_N),
    .enable       (inact_en),
    .sample_valid (AUX_VALID),
    .hit          (magnitude < {1'b0, inact_limit}),
    .need         (counts_r[CNT_QUIET_LSB +: COUNT_W]),
    .event_pulse  (inact_pulse)
  );

  // Configuration writes; reserved bits masked off so they stay zero
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      act_hi_r    <= RST_REG;
      act_lo_r    <= RST_REG;
      inact_hi_r  <= RST_REG;
      inact_lo_r  <= RST_REG;
      counts_r    <= RST_REG;
      axis_mask_r <= RST_REG;
      conv_ctl_r  <= RST_CONV_CTL;
      therm_ctl_r <= RST_REG;
      irq_enable_r <= 2'h0;
    end else if (wr_acc) begin
      if (word_idx == 10'(IDX_ACT_HI)) begin
        act_hi_r <= PWDATA[7:0] & MSK_LIM_HI;
      end else if (word_idx == 10'(IDX_ACT_LO)) begin
        act_lo_r <= PWDATA[7:0] & MSK_LIM_LO;
      end else if (word_idx == 10'(IDX_INACT_HI)) begin
        inact_hi_r <= PWDATA[7:0] & MSK_LIM_HI;
      end else if (word_idx == 10'(IDX_INACT_LO)) begin
        inact_lo_r <= PWDATA[7:0] & MSK_LIM_LO;
      end else if (word_idx == 10'(IDX_COUNTS)) begin
        counts_r <= PWDATA[7:0] & MSK_COUNTS;
      end else if (word_idx == 10'(IDX_AXIS_MASK)) begin
        axis_mask_r <= PWDATA[7:0] & MSK_AXIS;
      end else if (word_idx == 10'(IDX_CONV_CTL)) begin
        conv_ctl_r <= PWDATA[7:0] & MSK_CTL;
      end else if (word_idx == 10'(IDX_THERM_CTL)) begin
        therm_ctl_r <= PWDATA[7:0] & MSK_CTL;
      end else if (word_idx == 10'(IDX_IRQ_ENABLE)) begin
        irq_enable_r <= PWDATA[1:0];
      end
    end
  end

  // Write-one-to-clear strobe for the sticky status
  assign clr_bits = (wr_acc && word_idx == 10'(IDX_IRQ_CLEAR)) ? PWDATA[1:0] : 2'h0;

  // Sticky event status; a new event wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_status_r <= 2'h0;
    end else begin
      irq_status_r[IRQ_ACT_BIT]   <= act_pulse || (irq_status_r[IRQ_ACT_BIT] && !clr_bits[IRQ_ACT_BIT]);
      irq_status_r[IRQ_INACT_BIT] <= inact_pulse || (irq_status_r[IRQ_INACT_BIT] && !clr_bits[IRQ_INACT_BIT]);
    end
  end

  // Level interrupt from enabled status bits
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status_next() & irq_enable_r);
    end
  end

  function automatic logic [1:0] irq_status_next();
    logic [1:0] v;
    v[IRQ_ACT_BIT]   = act_pulse || (irq_status_r[IRQ_ACT_BIT] && !clr_bits[IRQ_ACT_BIT]);
    v[IRQ_INACT_BIT] = inact_pulse || (irq_status_r[IRQ_INACT_BIT] && !clr_bits[IRQ_INACT_BIT]);
    return v;
  endfunction

  // Read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_nxt = 8'h00;
    idx_ok = 1'b1;
    if (word_idx == 10'(IDX_ACT_HI)) begin
      rd_nxt = act_hi_r;
    end else if (word_idx == 10'(IDX_ACT_LO)) begin
      rd_nxt = act_lo_r;
    end else if (word_idx == 10'(IDX_INACT_HI)) begin
      rd_nxt = inact_hi_r;
    end else if (word_idx == 10'(IDX_INACT_LO)) begin
      rd_nxt = inact_lo_r;
    end else if (word_idx == 10'(IDX_COUNTS)) begin
      rd_nxt = counts_r;
    end else if (word_idx == 10'(IDX_AXIS_MASK)) begin
      rd_nxt = axis_mask_r;
    end else if (word_idx == 10'(IDX_CONV_CTL)) begin
      rd_nxt = conv_ctl_r;
    end else if (word_idx == 10'(IDX_THERM_CTL)) begin
      rd_nxt = therm_ctl_r;
    end else if (word_idx == 10'(IDX_IRQ_STATUS)) begin
      rd_nxt = {6'h00, irq_status_r};
    end else if (word_idx == 10'(IDX_IRQ_ENABLE)) begin
      rd_nxt = {6'h00, irq_enable_r};
    end else if (word_idx == 10'(IDX_IRQ_CLEAR)) begin
      rd_nxt = 8'h00; // Write-only, reads zero
    end else begin
      idx_ok = 1'b0;
    end
  end

  // APB answer: one wait state, PREADY high in the second access cycle
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !idx_ok;
      PRDATA  <= rd_acc ? {24'h000000, rd_nxt} : 32'h0000_0000;
    end
  end

  // Tap axis routing and per-axis check enables
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      TAP_SAMPLE <= '0;
      X_CHECK_EN <= 1'b1;
      Y_CHECK_EN <= 1'b1;
      Z_CHECK_EN <= 1'b1;
    end else begin
      X_CHECK_EN <= !axis_mask_r[MASK_X_BIT];
      Y_CHECK_EN <= !axis_mask_r[MASK_Y_BIT];
      Z_CHECK_EN <= !axis_mask_r[MASK_Z_BIT];
      if (AXIS_VALID) begin
        case (axis_mask_r[TAP_AXIS_LSB +: 2])
          TAP_X:   TAP_SAMPLE <= ACCEL_X;
          TAP_Y:   TAP_SAMPLE <= ACCEL_Y;
          TAP_Z:   TAP_SAMPLE <= ACCEL_Z;
          default: TAP_SAMPLE <= '0; // Code 11 selects no axis
        endcase
      end
    end
  end

  // Event pulses registered to the ports
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      AUX_ACT_EVENT   <= 1'b0;
      AUX_INACT_EVENT <= 1'b0;
    end else begin
      AUX_ACT_EVENT   <= act_pulse;
      AUX_INACT_EVENT <= inact_pulse;
    end
  end

  // Events gated by the enables of whichever source owns the channel
  act_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    act_pulse |-> $past(act_en)) else $error("activity event while disabled");
  inact_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    inact_pulse |-> $past(inact_en)) else $error("inactivity event while disabled");
  therm_over_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    therm_on |-> !conv_on && act_en == therm_ctl_r[CTL_ACT_BIT] && inact_en == therm_ctl_r[CTL_INACT_BIT])
    else $error("converter active in thermal mode");
  conv_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !therm_on && !conv_on |-> !act_en && !inact_en) else $error("detection without a source");

  // Limit comparisons and run lengths
  act_hit_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    act_pulse |-> $past(magnitude > {1'b0, act_limit})) else $error("activity without exceeding limit");
  inact_hit_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    inact_pulse |-> $past(magnitude < {1'b0, inact_limit})) else $error("inactivity above limit");
  act_valid_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    act_pulse |-> $past(AUX_VALID)) else $error("activity without a sample");
  inact_valid_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    inact_pulse |-> $past(AUX_VALID)) else $error("inactivity without a sample");
  act_first_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    act_en && AUX_VALID && magnitude > {1'b0, act_limit} && counts_r[CNT_BUSY_LSB +: COUNT_W] <= 4'h1
    |=> act_pulse) else $error("short activity count missed");
  inact_first_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    inact_en && AUX_VALID && magnitude < {1'b0, inact_limit} && counts_r[CNT_QUIET_LSB +: COUNT_W] <= 4'h1
    |=> inact_pulse) else $error("short inactivity count missed");

  // Event ports trail the internal pulses by one cycle
  act_port_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    AUX_ACT_EVENT == $past(act_pulse)) else $error("activity port mismatch");
  inact_port_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    AUX_INACT_EVENT == $past(inact_pulse)) else $error("inactivity port mismatch");

  // Reserved bits never hold a one
  lo_rsvd_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    act_lo_r[1:0] == 2'h0 && inact_lo_r[1:0] == 2'h0 && act_hi_r[7] == 1'b0) else $error("reserved bit set");
  hi_rsvd_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    inact_hi_r[7] == 1'b0 && axis_mask_r[7:6] == 2'h0 && axis_mask_r[3] == 1'b0) else $error("reserved mask bit set");

  // Axis check enables follow the mask one cycle late
  zmask_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    axis_mask_r[MASK_Z_BIT] |=> !Z_CHECK_EN) else $error("z check not blocked");
  ymask_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    axis_mask_r[MASK_Y_BIT] |=> !Y_CHECK_EN) else $error("y check not blocked");
  xmask_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !axis_mask_r[MASK_X_BIT] |=> X_CHECK_EN) else $error("x check not enabled");
  zcheck_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !axis_mask_r[MASK_Z_BIT] |=> Z_CHECK_EN) else $error("z check not enabled");
  ycheck_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !axis_mask_r[MASK_Y_BIT] |=> Y_CHECK_EN) else $error("y check not enabled");
  xblock_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    axis_mask_r[MASK_X_BIT] |=> !X_CHECK_EN) else $error("x check not blocked");

  // Tap routing for every axis code
  tap_y_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    AXIS_VALID && axis_mask_r[5:4] == TAP_Y |=> TAP_SAMPLE == $past(ACCEL_Y)) else $error("tap axis y wrong");
  tap_x_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    AXIS_VALID && axis_mask_r[5:4] == TAP_X |=> TAP_SAMPLE == $past(ACCEL_X)) else $error("tap axis x wrong");
  tap_z_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    AXIS_VALID && axis_mask_r[5:4] == TAP_Z |=> TAP_SAMPLE == $past(ACCEL_Z)) else $error("tap axis z wrong");
  tap_none_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    AXIS_VALID && axis_mask_r[5:4] == 2'h3 |=> TAP_SAMPLE == '0) else $error("tap code 11 not zero");

  // Sticky status and interrupt level; enable changes reach the pin one cycle late
  sticky_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    act_pulse |=> irq_status_r[IRQ_ACT_BIT]) else $error("status not set");
  inact_sticky_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    inact_pulse |=> irq_status_r[IRQ_INACT_BIT]) else $error("inactivity status not set");
  status_clr_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    clr_bits[IRQ_ACT_BIT] && !act_pulse |=> !irq_status_r[IRQ_ACT_BIT]) else $error("status not cleared");
  irq_level_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    IRQ == |(irq_status_r & $past(irq_enable_r))) else $error("interrupt level wrong");

  // APB answer timing and idle values
  apb_wait_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    PSEL && PENABLE && !PREADY |=> PREADY) else $error("apb answer late");
  apb_one_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    PREADY |=> !PREADY) else $error("apb ready held too long");
  apb_err_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    PSEL && PENABLE && !PREADY && !idx_ok |=> PSLVERR) else $error("unmapped access not flagged");
  apb_idle_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !PREADY |-> PRDATA == 32'h0000_0000 && !PSLVERR) else $error("apb outputs not idle");

  // Main scenarios reached
  act_cov: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) AUX_ACT_EVENT);
  inact_cov: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) AUX_INACT_EVENT);
  irq_cov: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) IRQ);
  conv_cov: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) conv_on && act_pulse);
  tap_cov: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) AXIS_VALID && axis_mask_r[5:4] == TAP_Z);
endmodule
